// *** src/ufc_pkg.sv ***
// ufc_pkg: register map, field positions, timing constants and shared
// types of the serial channel control block.
// assumes an AHB-Lite register bus with 32-bit data, one register a word.
package ufc_pkg;
	// ==========================================================
	// register indices (byte address is four times the index)
	localparam int unsigned IDX_W = 16;
	localparam int unsigned IDX_SHIFT = 2;
	localparam logic [15:0] IDX_STATUS = 16'h4100;
	localparam logic [15:0] IDX_TXDATA = 16'h4101;
	localparam logic [15:0] IDX_RXDATA = 16'h4102;
	localparam logic [15:0] IDX_FORMAT = 16'h4103;
	localparam logic [15:0] IDX_CONTROL = 16'h4104;
	localparam logic [15:0] IDX_EXPANSION = 16'h4105;
	localparam logic [15:0] IDX_BAUD = 16'h4106;
	localparam logic [15:0] IDX_FINE = 16'h4107;
	// ==========================================================
	// field positions
	localparam int unsigned FMT_CHAR8 = 4;
	localparam int unsigned FMT_PAR_EN = 3;
	localparam int unsigned FMT_PAR_ODD = 2;
	localparam int unsigned FMT_TWO_STOP = 1;
	localparam int unsigned CTL_TXDONE_IE = 7;
	localparam int unsigned CTL_RXERR_IE = 6;
	localparam int unsigned CTL_RXFULL_IE = 5;
	localparam int unsigned CTL_TXEMPTY_IE = 4;
	localparam int unsigned CTL_RX_THR = 1;
	localparam int unsigned CTL_CHAN_EN = 0;
	localparam int unsigned EXP_IR = 0;
	localparam int unsigned ST_TX_DONE = 7;
	localparam int unsigned ST_FRAME_ERR = 6;
	localparam int unsigned ST_PARITY_ERR = 5;
	localparam int unsigned ST_OVERRUN = 4;
	// writable bit masks, reserved bits read zero
	localparam logic [7:0] FMT_MASK = 8'h1E;
	localparam logic [7:0] CTL_MASK = 8'hF3;
	localparam logic [7:0] EXP_MASK = 8'h01;
	localparam logic [7:0] FINE_MASK = 8'h0F;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ==========================================================
	// timing: sixteen generator ticks to one serial bit
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] TICK_MID = 4'h7;
	localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
	localparam logic [2:0] LAST_BIT_8 = 3'h7;
	localparam logic [2:0] LAST_BIT_7 = 3'h6;
	// per slot of sixteen underflows, least fine value that delays it; zero marks a slot never delayed
	localparam logic [63:0] FINE_THRESH = 64'h195D3B7F2A6E4C80;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	// ==========================================================
	// types
	typedef struct packed {
		logic char8;
		logic par_en;
		logic par_odd;
		logic two_stop;
	} ufc_cfg_type;
	typedef enum logic [4:0] {
		FR_IDLE = 5'b00001,
		FR_START = 5'b00010,
		FR_DATA = 5'b00100,
		FR_PARITY = 5'b01000,
		FR_STOP = 5'b10000
	} ufc_frame_state_type;
endpackage : ufc_pkg

// *** src/ufc_baud_gen.sv ***
// ufc_baud_gen: reload counter that yields one tick per underflow period,
// stretched by one cycle in the slots picked by the fine setting.
// assumes the count clock is hclk itself.
`timescale 1ns/1ns
`default_nettype none
module ufc_baud_gen import ufc_pkg::*; #(
	parameter int unsigned BAUD_W = 8,
	parameter int unsigned FINE_W = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic [BAUD_W-1:0] reload,
	input wire logic [FINE_W-1:0] fine,
	output logic tick
);
	generate
		if (FINE_W != 4 || BAUD_W < 1) begin : g_bad
			$error("ufc_baud_gen: fine width must be 4");
		end
	endgenerate

	logic [BAUD_W-1:0] cnt_reg;
	logic [3:0] slot_reg;
	logic stall_reg;

	// true when this slot of sixteen takes an extra cycle
	function automatic logic slot_delayed(input logic [3:0] slot, input logic [3:0] f);
		logic [3:0] thr;
		thr = FINE_THRESH[{slot, 2'b00} +: 4];
		return (thr != 4'h0) && (f >= thr);
	endfunction : slot_delayed

	// ==========================================================
	// count down, reload at underflow, insert delay cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= '0;
			slot_reg <= 4'h0;
			stall_reg <= 1'b0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_reg <= reload;
			slot_reg <= 4'h0;
			stall_reg <= 1'b0;
			tick <= 1'b0;
		end else if (stall_reg) begin
			stall_reg <= 1'b0; // one count clock added
			tick <= 1'b1;
			cnt_reg <= reload;
			slot_reg <= slot_reg + 4'h1;
		end else if (cnt_reg == '0) begin
			if (slot_delayed(slot_reg, fine)) begin
				stall_reg <= 1'b1;
				tick <= 1'b0;
			end else begin
				tick <= 1'b1;
				cnt_reg <= reload;
				slot_reg <= slot_reg + 4'h1;
			end
		end else begin
			cnt_reg <= cnt_reg - 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : ufc_baud_gen
`default_nettype wire

// *** src/ufc_uart_ctrl.sv ***
// ufc_uart_ctrl: serial channel with frame format, enable, four interrupt
// requests, two-entry receive buffer, infrared coding and baud generator.
// assumes one AHB-Lite master, sin asynchronous to hclk, hclk = count clock.
`timescale 1ns/1ns
`default_nettype none
module ufc_uart_ctrl import ufc_pkg::*; #(
	parameter int unsigned ADDR_W = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic sin,
	output logic sout,
	output logic tx_done_irq,
	output logic rx_error_irq,
	output logic rx_full_irq,
	output logic tx_empty_irq
);
	generate
		if (ADDR_W < IDX_W + IDX_SHIFT) begin : g_bad
			$error("ufc_uart_ctrl: address too narrow for register map");
		end
	endgenerate

	// ==========================================================
	// declarations
	logic [7:0] format_reg, control_reg, expansion_reg, baud_reg, fine_reg;
	logic wr_pend_reg;
	logic [IDX_W-1:0] wr_idx_reg;
	logic sin_meta_reg, sin_sync_reg;
	logic [7:0] txbuf_reg;
	logic txbuf_full_reg;
	logic tx_done_reg, frame_err_reg, parity_err_reg, overrun_reg;
	logic [7:0] fifo0_reg, fifo1_reg;
	logic [1:0] count_reg;
	ufc_frame_state_type tx_state_reg, rx_state_reg;
	logic [3:0] ttick_reg, rtick_reg;
	logic [7:0] tsh_reg, rsh_reg;
	logic [2:0] tbit_reg, rbit_reg;
	logic tpar_reg, rpar_reg, tstop_reg, rstop_reg;
	logic mid_reg, seen_reg, ferr_pend_reg, perr_pend_reg;
	logic tick, ap_valid, ap_map, rd_pop;
	logic wr_status, wr_ctl, wr_tx, tx_load, tx_fin, rx_push, push_ok;
	logic t_end, r_end, r_bitval, tx_bit;
	logic [2:0] last_bit;
	logic [7:0] rx_char, rd_val;
	ufc_cfg_type cfg;
	logic chan_en, ir_mode;

	// index of an address, and whether it lands on a word of the map
	function automatic logic [IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
		return a[IDX_SHIFT +: IDX_W];
	endfunction : addr_idx

	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		return (a >> (IDX_SHIFT + IDX_W)) == '0 && a[IDX_SHIFT-1:0] == '0;
	endfunction : addr_ok

	// ==========================================================
	// bus address phase
	assign ap_valid = hsel && hready && htrans[1];
	assign ap_map = addr_ok(haddr);
	assign rd_pop = ap_valid && !hwrite && ap_map && addr_idx(haddr) == IDX_RXDATA
		&& count_reg != 2'd0;
	assign wr_status = wr_pend_reg && wr_idx_reg == IDX_STATUS;
	assign wr_ctl = wr_pend_reg && wr_idx_reg == IDX_CONTROL;
	assign wr_tx = wr_pend_reg && wr_idx_reg == IDX_TXDATA && chan_en;

	assign cfg.char8 = format_reg[FMT_CHAR8];
	assign cfg.par_en = format_reg[FMT_PAR_EN];
	assign cfg.par_odd = format_reg[FMT_PAR_ODD];
	assign cfg.two_stop = format_reg[FMT_TWO_STOP];
	assign chan_en = control_reg[CTL_CHAN_EN];
	assign ir_mode = expansion_reg[EXP_IR];
	assign last_bit = cfg.char8 ? LAST_BIT_8 : LAST_BIT_7;

	// read mux; reserved bits come back zero
	always_comb begin
		rd_val = 8'h00;
		unique case (addr_idx(haddr))
			IDX_STATUS: rd_val = {tx_done_reg, frame_err_reg, parity_err_reg, overrun_reg,
				count_reg == 2'd2, tx_state_reg != FR_IDLE, count_reg != 2'd0,
				!txbuf_full_reg};
			IDX_TXDATA: rd_val = txbuf_reg;
			IDX_RXDATA: rd_val = fifo0_reg;
			IDX_FORMAT: rd_val = format_reg;
			IDX_CONTROL: rd_val = control_reg;
			IDX_EXPANSION: rd_val = expansion_reg;
			IDX_BAUD: rd_val = baud_reg;
			IDX_FINE: rd_val = fine_reg;
			default: rd_val = 8'h00;
		endcase
		if (!ap_map) begin
			rd_val = 8'h00;
		end
	end

	// zero-wait slave: read data registered at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= '0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0; // always OKAY
			wr_pend_reg <= ap_valid && hwrite && ap_map;
			wr_idx_reg <= addr_idx(haddr);
			if (ap_valid && !hwrite) begin
				hrdata <= {24'h00_0000, rd_val};
			end
		end
	end

	// ==========================================================
	// configuration registers, written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			format_reg <= REG_RESET;
			control_reg <= REG_RESET;
			expansion_reg <= REG_RESET;
			baud_reg <= REG_RESET;
			fine_reg <= REG_RESET;
		end else if (wr_pend_reg) begin
			unique case (wr_idx_reg)
				IDX_FORMAT: format_reg <= hwdata[7:0] & FMT_MASK;
				IDX_CONTROL: control_reg <= hwdata[7:0] & CTL_MASK;
				IDX_EXPANSION: expansion_reg <= hwdata[7:0] & EXP_MASK;
				IDX_BAUD: baud_reg <= hwdata[7:0];
				IDX_FINE: fine_reg <= hwdata[7:0] & FINE_MASK;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// baud generator, halted while the channel is off
	ufc_baud_gen #(
		.BAUD_W(8),
		.FINE_W(4)
	) u_baud (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(chan_en),
		.reload(baud_reg),
		.fine(fine_reg[3:0]),
		.tick(tick)
	);

	// line input synchroniser
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sin_meta_reg <= 1'b1;
			sin_sync_reg <= 1'b1;
		end else begin
			sin_meta_reg <= sin;
			sin_sync_reg <= sin_meta_reg;
		end
	end

	// ==========================================================
	// transmit buffer; disabling the channel drops its content
	// the move waits for a tick so the start bit lasts a whole bit time
	assign tx_load = chan_en && txbuf_full_reg && tx_state_reg == FR_IDLE && tick;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txbuf_reg <= 8'h00;
			txbuf_full_reg <= 1'b0;
		end else if (!chan_en || (wr_ctl && !hwdata[CTL_CHAN_EN])) begin
			txbuf_full_reg <= 1'b0;
		end else if (wr_tx) begin
			txbuf_reg <= hwdata[7:0];
			txbuf_full_reg <= 1'b1;
		end else if (tx_load) begin
			txbuf_full_reg <= 1'b0;
		end
	end

	// ==========================================================
	// transmit frame sequencer
	assign t_end = tick && ttick_reg == TICK_LAST;
	assign tx_fin = t_end && tx_state_reg == FR_STOP && !(cfg.two_stop && !tstop_reg);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_state_reg <= FR_IDLE;
			ttick_reg <= 4'h0;
			tsh_reg <= 8'h00;
			tbit_reg <= 3'h0;
			tpar_reg <= 1'b0;
			tstop_reg <= 1'b0;
		end else if (!chan_en || (wr_ctl && !hwdata[CTL_CHAN_EN])) begin
			tx_state_reg <= FR_IDLE;
		end else begin
			if (tick) begin
				ttick_reg <= ttick_reg + 4'h1;
			end
			unique case (tx_state_reg)
				FR_IDLE: if (tx_load) begin
					tsh_reg <= txbuf_reg;
					ttick_reg <= 4'h0;
					tbit_reg <= 3'h0;
					tpar_reg <= 1'b0;
					tstop_reg <= 1'b0;
					tx_state_reg <= FR_START;
				end
				FR_START: if (t_end) begin
					tx_state_reg <= FR_DATA;
				end
				FR_DATA: if (t_end) begin
					tsh_reg <= tsh_reg >> 1;
					tpar_reg <= tpar_reg ^ tsh_reg[0];
					tbit_reg <= tbit_reg + 3'h1;
					if (tbit_reg == last_bit) begin
						tx_state_reg <= cfg.par_en ? FR_PARITY : FR_STOP;
					end
				end
				FR_PARITY: if (t_end) begin
					tx_state_reg <= FR_STOP;
				end
				FR_STOP: if (t_end) begin
					tstop_reg <= 1'b1;
					if (tx_fin) begin
						tx_state_reg <= FR_IDLE;
					end
				end
			endcase
		end
	end

	// line level of the bit now on the wire
	always_comb begin
		unique case (tx_state_reg)
			FR_START: tx_bit = 1'b0;
			FR_DATA: tx_bit = tsh_reg[0];
			FR_PARITY: tx_bit = tpar_reg ^ cfg.par_odd;
			default: tx_bit = 1'b1;
		endcase
	end

	// infrared sends a short high pulse for each zero bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sout <= 1'b1;
		end else if (ir_mode) begin
			sout <= !tx_bit && ttick_reg < IR_PULSE_TICKS;
		end else begin
			sout <= tx_bit;
		end
	end

	// ==========================================================
	// receive frame sequencer, bit value judged at the last tick
	assign r_end = tick && rtick_reg == TICK_LAST;
	assign r_bitval = ir_mode ? !seen_reg : mid_reg;
	assign rx_push = r_end && rx_state_reg == FR_STOP && !(cfg.two_stop && !rstop_reg);
	assign rx_char = cfg.char8 ? rsh_reg : {1'b0, rsh_reg[7:1]};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state_reg <= FR_IDLE;
			rtick_reg <= 4'h0;
			rsh_reg <= 8'h00;
			rbit_reg <= 3'h0;
			rpar_reg <= 1'b0;
			rstop_reg <= 1'b0;
			mid_reg <= 1'b1;
			seen_reg <= 1'b0;
			ferr_pend_reg <= 1'b0;
			perr_pend_reg <= 1'b0;
		end else if (!chan_en) begin
			rx_state_reg <= FR_IDLE;
			seen_reg <= 1'b0;
		end else begin
			if (tick) begin
				rtick_reg <= rtick_reg + 4'h1;
			end
			if (tick && rtick_reg == TICK_MID) begin
				mid_reg <= sin_sync_reg;
			end
			if (r_end) begin
				seen_reg <= 1'b0;
			end else if (sin_sync_reg) begin
				seen_reg <= 1'b1;
			end
			unique case (rx_state_reg)
				FR_IDLE: if (ir_mode ? sin_sync_reg : !sin_sync_reg) begin
					rtick_reg <= 4'h0;
					rbit_reg <= 3'h0;
					rpar_reg <= 1'b0;
					rstop_reg <= 1'b0;
					ferr_pend_reg <= 1'b0;
					perr_pend_reg <= 1'b0;
					rx_state_reg <= FR_START;
				end
				FR_START: if (r_end) begin
					// a start that does not hold low is a glitch
					rx_state_reg <= r_bitval ? FR_IDLE : FR_DATA;
				end
				FR_DATA: if (r_end) begin
					rsh_reg <= {r_bitval, rsh_reg[7:1]};
					rpar_reg <= rpar_reg ^ r_bitval;
					rbit_reg <= rbit_reg + 3'h1;
					if (rbit_reg == last_bit) begin
						rx_state_reg <= cfg.par_en ? FR_PARITY : FR_STOP;
					end
				end
				FR_PARITY: if (r_end) begin
					perr_pend_reg <= (rpar_reg ^ r_bitval) != cfg.par_odd;
					rx_state_reg <= FR_STOP;
				end
				FR_STOP: if (r_end) begin
					rstop_reg <= 1'b1;
					if (!r_bitval) begin
						ferr_pend_reg <= 1'b1;
					end
					if (rx_push) begin
						rx_state_reg <= FR_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// two-entry receive buffer, oldest in fifo0_reg; full buffer is kept
	assign push_ok = rx_push && (count_reg != 2'd2 || rd_pop);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fifo0_reg <= 8'h00;
			fifo1_reg <= 8'h00;
			count_reg <= 2'd0;
		end else begin
			unique case ({push_ok, rd_pop})
				2'b10: begin
					if (count_reg == 2'd0) begin
						fifo0_reg <= rx_char;
					end else begin
						fifo1_reg <= rx_char;
					end
					count_reg <= count_reg + 2'd1;
				end
				2'b01: begin
					fifo0_reg <= fifo1_reg;
					count_reg <= count_reg - 2'd1;
				end
				2'b11: begin
					if (count_reg == 2'd1) begin
						fifo0_reg <= rx_char;
					end else begin
						fifo0_reg <= fifo1_reg;
						fifo1_reg <= rx_char;
					end
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// sticky status flags, write one to clear, a new event wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_done_reg <= 1'b0;
			frame_err_reg <= 1'b0;
			parity_err_reg <= 1'b0;
			overrun_reg <= 1'b0;
		end else begin
			tx_done_reg <= tx_fin || (tx_done_reg && !(wr_status && hwdata[ST_TX_DONE]));
			frame_err_reg <= (rx_push && (ferr_pend_reg || !r_bitval)) // last stop bit too
				|| (frame_err_reg && !(wr_status && hwdata[ST_FRAME_ERR]));
			parity_err_reg <= (rx_push && perr_pend_reg)
				|| (parity_err_reg && !(wr_status && hwdata[ST_PARITY_ERR]));
			overrun_reg <= (rx_push && !push_ok)
				|| (overrun_reg && !(wr_status && hwdata[ST_OVERRUN]));
		end
	end

	// ==========================================================
	// interrupt requests: enable and condition, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_done_irq <= 1'b0;
			rx_error_irq <= 1'b0;
			rx_full_irq <= 1'b0;
			tx_empty_irq <= 1'b0;
		end else begin
			tx_done_irq <= control_reg[CTL_TXDONE_IE] && tx_done_reg;
			rx_error_irq <= control_reg[CTL_RXERR_IE]
				&& (frame_err_reg || parity_err_reg || overrun_reg);
			rx_full_irq <= control_reg[CTL_RXFULL_IE] && (control_reg[CTL_RX_THR]
				? count_reg == 2'd2 : count_reg != 2'd0);
			// level while the channel is on and the transmit buffer is empty
			tx_empty_irq <= control_reg[CTL_TXEMPTY_IE] && chan_en
				&& !txbuf_full_reg;
		end
	end
endmodule : ufc_uart_ctrl
`default_nettype wire

// *** test/ufc_peer.sv ***
// ufc_peer: remote serial transceiver on the sin and sout lines.
// assumes callers step on a rising hclk edge; periods are in hclk cycles.
`timescale 1ns/1ns
`default_nettype none
module ufc_peer (
	input wire logic hclk,
	input wire logic sout,
	output logic sin
);
	// ==========
	// transmit side: line rests high between frames
	initial sin = 1'b1;
	task send(input logic [11:0] b, input int n, input int p);
		for (int i = 0; i < n; i++) begin
			sin <= b[i];
			repeat (p) @(posedge hclk);
		end
		sin <= 1'b1;
	endtask : send
	// ==========
	// receive side: mid-bit sampling after the start edge
	task grab(input int n, input int p, output logic [11:0] b);
		b = 12'h000;
		while (sout !== 1'b0) @(posedge hclk);
		repeat (p / 2) @(posedge hclk);
		for (int i = 0; i < n; i++) begin
			b[i] = sout;
			repeat (p) @(posedge hclk);
		end
	endtask : grab
	// low run length, exact because sout only moves on edges
	task low_run(output int c);
		c = 0;
		while (sout !== 1'b0) @(posedge hclk);
		while (sout === 1'b0) begin
			c++;
			@(posedge hclk);
		end
	endtask : low_run
endmodule : ufc_peer
`default_nettype wire

// *** test/ufc_uart_ctrl_chk.sv ***
// ufc_uart_ctrl_chk: port-level assertions for the serial channel block.
// assumes a zero-wait slave; control writes are shadowed from the bus.
`timescale 1ns/1ns
`default_nettype none
module ufc_uart_ctrl_chk import ufc_pkg::*; #(
	parameter int unsigned ADDR_W = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic tx_done_irq,
	input wire logic rx_error_irq,
	input wire logic rx_full_irq,
	input wire logic tx_empty_irq
);
	// ==========
	// helper logic
	logic hit;
	logic wr_q;
	logic rd_q;
	logic [15:0] idx_q;
	logic [7:0] ctl_sh;
	assign hit = hsel && htrans[1] && haddr[1:0] == 2'h0 && haddr[ADDR_W-1:18] == '0;
	// address phase kept so the data phase knows its target
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			idx_q <= 16'h0000;
		end else if (hready) begin
			wr_q <= hit && hwrite;
			rd_q <= hit && !hwrite;
			idx_q <= haddr[17:2];
		end
	end
	// shadow of control; irqs are judged against what software enabled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_sh <= 8'h00;
		end else if (wr_q && idx_q == IDX_CONTROL) begin
			ctl_sh <= hwdata[7:0];
		end
	end
	// ==========
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_txdone_off;
		!ctl_sh[CTL_TXDONE_IE] [*2] |=> !tx_done_irq;
	endproperty
	a_txdone_off: assert property (p_txdone_off) else $error("end irq while masked");
	property p_rxerr_off;
		!ctl_sh[CTL_RXERR_IE] [*2] |=> !rx_error_irq;
	endproperty
	a_rxerr_off: assert property (p_rxerr_off) else $error("error irq while masked");
	property p_rxfull_off;
		!ctl_sh[CTL_RXFULL_IE] [*2] |=> !rx_full_irq;
	endproperty
	a_rxfull_off: assert property (p_rxfull_off) else $error("full irq while masked");
	property p_txempty_off;
		!ctl_sh[CTL_TXEMPTY_IE] [*2] |=> !tx_empty_irq;
	endproperty
	a_txempty_off: assert property (p_txempty_off) else $error("empty irq while masked");
	property p_chan_off;
		!ctl_sh[CTL_CHAN_EN] [*3] |-> !tx_empty_irq;
	endproperty
	a_chan_off: assert property (p_chan_off) else $error("empty irq while off");
	property p_fmt_rsvd;
		rd_q && idx_q == IDX_FORMAT |-> hrdata[7:5] == 3'h0 && !hrdata[0] && hrdata[31:8] == '0;
	endproperty
	a_fmt_rsvd: assert property (p_fmt_rsvd) else $error("format reserved bits set");
	property p_ctl_rsvd;
		rd_q && idx_q == IDX_CONTROL |-> hrdata[3:2] == 2'h0
			&& hrdata[7:0] == ($past(ctl_sh) & 8'hF3);
	endproperty
	a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control readback wrong");
	property p_stat_off;
		rd_q && idx_q == IDX_STATUS && !ctl_sh[0] && !$past(ctl_sh[0]) |-> hrdata[0] && !hrdata[2];
	endproperty
	a_stat_off: assert property (p_stat_off) else $error("tx buffer kept while off");
endmodule : ufc_uart_ctrl_chk
bind ufc_uart_ctrl ufc_uart_ctrl_chk #(.ADDR_W(ADDR_W)) i_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.tx_done_irq(tx_done_irq), .rx_error_irq(rx_error_irq),
	.rx_full_irq(rx_full_irq), .tx_empty_irq(tx_empty_irq)
);
`default_nettype wire

// *** test/tb.sv ***
// tb: self-checking bench for the serial channel control block.
// assumes the package and design are compiled first; one master, one peer.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import ufc_pkg::*;
	// ==========
	// signals
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic hreadyout, hresp, sin, sout, txd_irq, rxe_irq, rxf_irq, txe_irq;
	logic [31:0] hrdata;
	logic [7:0] q8;
	logic [11:0] fr;
	int failures = 0;
	int tests_run = 0;
	int n;
	// 250 MHz clock
	always #2 hclk = ~hclk;
	ufc_uart_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sin(sin), .sout(sout),
		.tx_done_irq(txd_irq), .rx_error_irq(rxe_irq), .rx_full_irq(rxf_irq),
		.tx_empty_irq(txe_irq));
	ufc_peer i_peer (.hclk(hclk), .sout(sout), .sin(sin));
	// ==========
	// shared tasks: compare, one bus transfer, register helpers
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task xfer(input logic w, input logic [15:0] i, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {14'h0000, i, 2'b00};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q8 = hrdata[7:0];
	endtask : xfer
	task wr(input logic [15:0] i, input logic [7:0] d);
		xfer(1'b1, i, d);
	endtask : wr
	task rdc(input string nm, input logic [15:0] i, input logic [7:0] e);
		xfer(1'b0, i, 8'h00);
		chk(nm, e, q8);
	endtask : rdc
	// ==========
	// reset values and reserved bits of every control register
	task t_regs;
		logic [15:0] ix [5];
		logic [7:0] mk [5];
		ix = '{IDX_FORMAT, IDX_CONTROL, IDX_EXPANSION, IDX_BAUD, IDX_FINE};
		mk = '{8'h1E, 8'hF3, 8'h01, 8'hFF, 8'h0F};
		for (int k = 0; k < 5; k++) begin
			rdc("reset value", ix[k], 8'h00);
			wr(ix[k], 8'hFF);
			rdc("masked value", ix[k], mk[k]);
			wr(ix[k], 8'h00);
		end
		rdc("unmapped", 16'h4108, 8'h00);
	endtask : t_regs
	// transmitted frames for several formats; expected frame built bit by bit
	task t_tx;
		logic [7:0] fm [4];
		logic [11:0] e;
		int nb;
		fm = '{8'h10, 8'h0A, 8'h1C, 8'h14};
		for (int k = 0; k < 4; k++) begin
			nb = fm[k][4] ? 8 : 7;
			e = 12'hFFF;
			e[0] = 1'b0;
			for (int i = 0; i < nb; i++) e[i + 1] = 8'hD3 >> i;
			n = nb + 1;
			if (fm[k][3]) begin
				e[n] = ^(8'hD3 & (fm[k][4] ? 8'hFF : 8'h7F)) ^ fm[k][2];
				n++;
			end
			n += fm[k][1] ? 2 : 1;
			wr(IDX_FORMAT, fm[k]);
			wr(IDX_BAUD, 8'(k % 2));
			wr(IDX_CONTROL, 8'h91);
			wr(IDX_TXDATA, 8'hD3);
			i_peer.grab(n, 16 * (k % 2 + 1), fr);
			chk("tx frame", e & ~(12'hFFF << n), fr);
			repeat (2) @(posedge hclk);
			chk("tx done irq", 1, txd_irq);
			chk("tx empty irq", 1, txe_irq);
			wr(IDX_STATUS, 8'h80);
			repeat (2) @(posedge hclk);
			chk("tx done irq cleared", 0, txd_irq);
			wr(IDX_CONTROL, 8'h00);
		end
	endtask : t_tx
	// low run of start bit plus eight zero bits gives the bit period
	task t_rate;
		int bv [3];
		int fv [3];
		bv = '{1, 2, 0};
		fv = '{5, 15, 1};
		for (int k = 0; k < 3; k++) begin
			wr(IDX_BAUD, 8'(bv[k]));
			wr(IDX_FINE, 8'(fv[k]));
			wr(IDX_CONTROL, 8'h01);
			wr(IDX_TXDATA, 8'h00);
			i_peer.low_run(n);
			chk("low run", 9 * (16 * (bv[k] + 1) + fv[k]), n);
			repeat (300) @(posedge hclk);
			wr(IDX_CONTROL, 8'h00);
		end
		wr(IDX_FINE, 8'h00);
	endtask : t_rate
	// two-entry receive buffer with threshold two, then framing and parity errors
	task t_rx;
		wr(IDX_STATUS, 8'hF0);
		wr(IDX_FORMAT, 8'h10);
		wr(IDX_CONTROL, 8'h63);
		i_peer.send({3'b111, 8'h3C, 1'b0}, 10, 16);
		repeat (24) @(posedge hclk);
		chk("full irq one char", 0, rxf_irq);
		i_peer.send({3'b111, 8'hC3, 1'b0}, 10, 16);
		repeat (24) @(posedge hclk);
		chk("full irq two chars", 1, rxf_irq);
		rdc("status two chars", IDX_STATUS, 8'h0B);
		rdc("first char", IDX_RXDATA, 8'h3C);
		rdc("status one char", IDX_STATUS, 8'h03);
		rdc("second char", IDX_RXDATA, 8'hC3);
		for (int k = 0; k < 2; k++) begin
			wr(IDX_CONTROL, 8'h00);
			wr(IDX_FORMAT, k ? 8'h18 : 8'h10);
			wr(IDX_CONTROL, 8'h41);
			i_peer.send(k ? {2'b11, 1'b0, 8'h01, 1'b0} : {3'b110, 8'h55, 1'b0}, 10 + k, 16);
			repeat (24) @(posedge hclk);
			chk("error irq", 1, rxe_irq);
			xfer(1'b0, IDX_STATUS, 8'h00);
			chk("error flags", k ? 8'h20 : 8'h40, q8 & 8'h70);
			wr(IDX_STATUS, 8'h70);
			repeat (2) xfer(1'b0, IDX_RXDATA, 8'h00);
			chk("error irq cleared", 0, rxe_irq);
		end
		wr(IDX_CONTROL, 8'h00);
	endtask : t_rx
	// disabling mid-frame drops the waiting character for good
	task t_off;
		wr(IDX_BAUD, 8'h0F);
		wr(IDX_CONTROL, 8'h01);
		wr(IDX_TXDATA, 8'h11);
		repeat (20) @(posedge hclk); // first character reaches the shifter
		wr(IDX_TXDATA, 8'h22);
		xfer(1'b0, IDX_STATUS, 8'h00);
		chk("buffer held", 8'h04, q8 & 8'h05);
		wr(IDX_CONTROL, 8'h00);
		xfer(1'b0, IDX_STATUS, 8'h00);
		chk("buffer dropped", 8'h01, q8 & 8'h05);
		chk("line idle", 1, sout);
		wr(IDX_TXDATA, 8'h33);
		wr(IDX_CONTROL, 8'h01);
		n = 0;
		repeat (600) begin
			@(posedge hclk);
			n += (sout === 1'b0);
		end
		chk("no frame after disable", 0, n);
		wr(IDX_CONTROL, 8'h00);
	endtask : t_off
	// infrared coding: idle low, one short pulse for the lone zero bit
	task t_ir;
		i_peer.sin <= 1'b0;
		wr(IDX_BAUD, 8'h00);
		wr(IDX_FORMAT, 8'h10);
		wr(IDX_EXPANSION, 8'h01);
		wr(IDX_CONTROL, 8'h01);
		repeat (4) @(posedge hclk);
		chk("ir idle", 0, sout);
		wr(IDX_TXDATA, 8'hFF);
		n = 0;
		repeat (200) begin
			@(posedge hclk);
			n += (sout === 1'b1);
		end
		chk("ir pulse cycles", 3, n);
		wr(IDX_CONTROL, 8'h00);
	endtask : t_ir
	// ==========
	// verdict, main sequence and watchdog
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_tx;
		t_rate;
		t_rx;
		t_off;
		t_ir;
		give_verdict;
	end
	// whole run needs about 5k cycles; allow 100k
	initial begin
		#400000;
		failures++;
		give_verdict;
	end
endmodule : tb
`default_nettype wire
